// ### include/rtcd_pkg.sv
// Constants shared by the time-of-day and day-count block
package rtcd_pkg;

  // ***************************************************************
  // Register offsets in the special function register space
  // ***************************************************************
  localparam logic [7:0] ADDR_SUBSECONDS = 8'hfa;
  localparam logic [7:0] ADDR_SECONDS = 8'hfb;
  localparam logic [7:0] ADDR_MINUTES = 8'hfc;
  localparam logic [7:0] ADDR_HOURS_WEEKDAY = 8'hfd;
  localparam logic [7:0] ADDR_DAY_COUNT_LOW = 8'hfe;
  localparam logic [7:0] ADDR_DAY_COUNT_HIGH = 8'hff;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int SECONDS_MSB = 5;
  localparam int MINUTES_MSB = 5;
  localparam int HOURS_MSB = 4;
  localparam int WEEKDAY_LSB = 5;
  localparam int WEEKDAY_MSB = 7;

  // ***************************************************************
  // Count limits
  // ***************************************************************
  localparam logic [7:0] SUBSECONDS_MAX = 8'hff;
  localparam logic [5:0] SECONDS_MAX = 6'h3b;
  localparam logic [5:0] MINUTES_MAX = 6'h3b;
  localparam logic [4:0] HOURS_MAX = 5'h17;
  localparam logic [2:0] WEEKDAY_FIRST = 3'h1;
  localparam logic [2:0] WEEKDAY_LAST = 3'h7;
  localparam logic [2:0] WEEKDAY_OFF = 3'h0;
  localparam logic [7:0] DAY_BYTE_MAX = 8'hff;

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [7:0] RST_SUBSECONDS = 8'h00;
  localparam logic [5:0] RST_SECONDS = 6'h00;
  localparam logic [5:0] RST_MINUTES = 6'h00;
  localparam logic [4:0] RST_HOURS = 5'h00;
  localparam logic [2:0] RST_WEEKDAY = 3'h0;
  localparam logic [7:0] RST_DAY_BYTE = 8'h00;
  localparam logic [7:0] RST_READ_DATA = 8'h00;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int unsigned CLK_RATE_HZ = 32'h0773_5940;
  localparam int unsigned SUBSECOND_RATE_HZ = 32'h0000_0100;
  // Longest period that fits, so rounded down
  localparam int unsigned SUBSECOND_TICK_CYCLES = CLK_RATE_HZ / SUBSECOND_RATE_HZ;

endpackage

// ### src/rtcd_tick_divider.sv
// Divider that makes the one-cycle subsecond tick enable
`timescale 1ns/1ps
`default_nettype none

module rtcd_tick_divider #(
  parameter int unsigned TICK_CYCLES = rtcd_pkg::SUBSECOND_TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  output logic tick
);

  // ***************************************************************
  // Cycle counter
  // ***************************************************************
  localparam int unsigned LAST = (TICK_CYCLES > 1) ? TICK_CYCLES - 1 : 0;

  logic [31:0] count_ff;
  logic [31:0] nxt_count;
  logic tick_ff;
  logic nxt_tick;

  always_comb begin
    if (count_ff >= LAST) begin
      nxt_count = 32'h0000_0000;
      nxt_tick = 1'b1;
    end else begin
      nxt_count = count_ff + 32'h0000_0001;
      nxt_tick = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= 32'h0000_0000;
      tick_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule

`default_nettype wire

// ### src/rtcd_time_counters.sv
// Time-of-day, weekday and relative day-count registers with their cascade
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Seconds in bits 5:0, bits 7:6 zero
// - Seconds count 0 to 59, then wrap
// - Minutes in bits 5:0, count 0 to 59
// - Hours in bits 4:0, count 0 to 23
// - Weekday bits 7:5, 1 to 7, on hour wrap
// - Weekday written zero stays zero, disabled
// - Reads return data only with read enable
// - Writes take effect only with write enable
// - Sixteen-bit day count over two bytes
// - Each day byte counts 0 to FFh
// - High byte rollover clears both bytes
// - No alarm compare on weekday or days
// - Subseconds 0 to FFh, read-only, cleared
module rtcd_time_counters #(
  parameter int unsigned TICK_CYCLES = rtcd_pkg::SUBSECOND_TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clock_read_enable,
  input wire logic clock_write_enable,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_rd,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic sfr_sel,
  output logic [7:0] sfr_rdata
);

  // ***************************************************************
  // Timebase
  // ***************************************************************
  logic tick;

  rtcd_tick_divider #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  // ***************************************************************
  // State
  // ***************************************************************
  logic [7:0] clock_subseconds_ff;
  logic [5:0] clock_seconds_ff;
  logic [5:0] clock_minutes_ff;
  logic [4:0] clock_hours_ff;
  logic [2:0] weekday_field_ff;
  logic [7:0] day_count_low_ff;
  logic [7:0] day_count_high_ff;
  logic write_enable_ff;
  logic [7:0] rdata_ff;

  logic [7:0] nxt_clock_subseconds;
  logic [5:0] nxt_clock_seconds;
  logic [5:0] nxt_clock_minutes;
  logic [4:0] nxt_clock_hours;
  logic [2:0] nxt_weekday_field;
  logic [7:0] nxt_day_count_low;
  logic [7:0] nxt_day_count_high;
  logic [7:0] nxt_rdata;

  // ***************************************************************
  // Address decode
  // ***************************************************************
  logic hit_sub;
  logic hit_sec;
  logic hit_min;
  logic hit_hour;
  logic hit_dlo;
  logic hit_dhi;
  logic wr_ok;

  always_comb begin
    hit_sub = 1'b0;
    hit_sec = 1'b0;
    hit_min = 1'b0;
    hit_hour = 1'b0;
    hit_dlo = 1'b0;
    hit_dhi = 1'b0;
    if (sfr_addr == rtcd_pkg::ADDR_SUBSECONDS) begin
      hit_sub = 1'b1;
    end else if (sfr_addr == rtcd_pkg::ADDR_SECONDS) begin
      hit_sec = 1'b1;
    end else if (sfr_addr == rtcd_pkg::ADDR_MINUTES) begin
      hit_min = 1'b1;
    end else if (sfr_addr == rtcd_pkg::ADDR_HOURS_WEEKDAY) begin
      hit_hour = 1'b1;
    end else if (sfr_addr == rtcd_pkg::ADDR_DAY_COUNT_LOW) begin
      hit_dlo = 1'b1;
    end else if (sfr_addr == rtcd_pkg::ADDR_DAY_COUNT_HIGH) begin
      hit_dhi = 1'b1;
    end
  end

  // Select follows the address alone, ahead of any strobe
  assign sfr_sel = hit_sub | hit_sec | hit_min | hit_hour | hit_dlo | hit_dhi;
  // Writes without the enable bit fall on the floor, silently
  assign wr_ok = sfr_wr & clock_write_enable;

  // ***************************************************************
  // Carry chain
  // ***************************************************************
  // Compares are on equality, so an out-of-range value written by
  // software runs on to the field's binary overflow before it wraps.
  logic sub_wrap;
  logic sec_wrap;
  logic min_wrap;
  logic hour_wrap;
  logic dlo_wrap;
  logic dhi_wrap;
  logic we_falling;

  always_comb begin
    sub_wrap = tick && (clock_subseconds_ff == rtcd_pkg::SUBSECONDS_MAX);
    sec_wrap = sub_wrap && (clock_seconds_ff == rtcd_pkg::SECONDS_MAX);
    min_wrap = sec_wrap && (clock_minutes_ff == rtcd_pkg::MINUTES_MAX);
    hour_wrap = min_wrap && (clock_hours_ff == rtcd_pkg::HOURS_MAX);
    dlo_wrap = hour_wrap && (day_count_low_ff == rtcd_pkg::DAY_BYTE_MAX);
    dhi_wrap = dlo_wrap && (day_count_high_ff == rtcd_pkg::DAY_BYTE_MAX);
  end

  // ***************************************************************
  // Write-enable edge
  // ***************************************************************
  // Clearing on the fall rather than while low lets the clock run in
  // normal use; holding it clear would stop time whenever writes end.
  logic nxt_write_enable;

  always_comb begin
    nxt_write_enable = clock_write_enable;
    we_falling = write_enable_ff && !clock_write_enable;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      write_enable_ff <= 1'b0;
    end else begin
      write_enable_ff <= nxt_write_enable;
    end
  end

  // ***************************************************************
  // Next values of the time fields
  // ***************************************************************
  // A write to a field wins over its own carry in that cycle; carries
  // out of the old value still reach the fields above it.
  always_comb begin
    nxt_clock_subseconds = clock_subseconds_ff;
    nxt_clock_seconds = clock_seconds_ff;
    nxt_clock_minutes = clock_minutes_ff;
    nxt_clock_hours = clock_hours_ff;
    nxt_weekday_field = weekday_field_ff;

    // Subseconds: counted, or cleared on the write-enable fall; never written
    if (we_falling) begin
      nxt_clock_subseconds = rtcd_pkg::RST_SUBSECONDS;
    end else if (tick) begin
      nxt_clock_subseconds = clock_subseconds_ff + 8'h01;
    end

    // Seconds
    if (wr_ok && hit_sec) begin
      nxt_clock_seconds = sfr_wdata[rtcd_pkg::SECONDS_MSB:0];
    end else if (sec_wrap) begin
      nxt_clock_seconds = rtcd_pkg::RST_SECONDS;
    end else if (sub_wrap) begin
      nxt_clock_seconds = clock_seconds_ff + 6'h01;
    end

    // Minutes
    if (wr_ok && hit_min) begin
      nxt_clock_minutes = sfr_wdata[rtcd_pkg::MINUTES_MSB:0];
    end else if (min_wrap) begin
      nxt_clock_minutes = rtcd_pkg::RST_MINUTES;
    end else if (sec_wrap) begin
      nxt_clock_minutes = clock_minutes_ff + 6'h01;
    end

    // Hours
    if (wr_ok && hit_hour) begin
      nxt_clock_hours = sfr_wdata[rtcd_pkg::HOURS_MSB:0];
    end else if (hour_wrap) begin
      nxt_clock_hours = rtcd_pkg::RST_HOURS;
    end else if (min_wrap) begin
      nxt_clock_hours = clock_hours_ff + 5'h01;
    end

    // Weekday: zero parks the field, so no increment from zero
    if (wr_ok && hit_hour) begin
      nxt_weekday_field = sfr_wdata[rtcd_pkg::WEEKDAY_MSB:rtcd_pkg::WEEKDAY_LSB];
    end else if (hour_wrap) begin
      if (weekday_field_ff == rtcd_pkg::WEEKDAY_OFF) begin
        nxt_weekday_field = rtcd_pkg::WEEKDAY_OFF;
      end else if (weekday_field_ff == rtcd_pkg::WEEKDAY_LAST) begin
        nxt_weekday_field = rtcd_pkg::WEEKDAY_FIRST;
      end else begin
        nxt_weekday_field = weekday_field_ff + 3'h1;
      end
    end
  end

  // ***************************************************************
  // Next values of the day count
  // ***************************************************************
  // Relative count only; nothing here compares it against an alarm,
  // so weekday and day bytes never raise a match of their own.
  always_comb begin
    nxt_day_count_low = day_count_low_ff;
    nxt_day_count_high = day_count_high_ff;

    if (wr_ok && hit_dlo) begin
      nxt_day_count_low = sfr_wdata;
    end else if (dhi_wrap) begin
      nxt_day_count_low = rtcd_pkg::RST_DAY_BYTE;
    end else if (hour_wrap) begin
      nxt_day_count_low = day_count_low_ff + 8'h01;
    end

    if (wr_ok && hit_dhi) begin
      nxt_day_count_high = sfr_wdata;
    end else if (dhi_wrap) begin
      nxt_day_count_high = rtcd_pkg::RST_DAY_BYTE;
    end else if (dlo_wrap) begin
      nxt_day_count_high = day_count_high_ff + 8'h01;
    end
  end

  // ***************************************************************
  // Read data
  // ***************************************************************
  // Read data is captured on the strobe and held until the next one,
  // so a late sample by the core still sees a stable byte.
  always_comb begin
    nxt_rdata = rdata_ff;
    if (sfr_rd) begin
      nxt_rdata = 8'h00;
      if (clock_read_enable) begin
        if (hit_sub) begin
          nxt_rdata = clock_subseconds_ff;
        end else if (hit_sec) begin
          nxt_rdata = {2'b00, clock_seconds_ff};
        end else if (hit_min) begin
          nxt_rdata = {2'b00, clock_minutes_ff};
        end else if (hit_hour) begin
          nxt_rdata = {weekday_field_ff, clock_hours_ff};
        end else if (hit_dlo) begin
          nxt_rdata = day_count_low_ff;
        end else if (hit_dhi) begin
          nxt_rdata = day_count_high_ff;
        end
      end
    end
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_subseconds_ff <= rtcd_pkg::RST_SUBSECONDS;
      clock_seconds_ff <= rtcd_pkg::RST_SECONDS;
      clock_minutes_ff <= rtcd_pkg::RST_MINUTES;
      clock_hours_ff <= rtcd_pkg::RST_HOURS;
      weekday_field_ff <= rtcd_pkg::RST_WEEKDAY;
    end else begin
      clock_subseconds_ff <= nxt_clock_subseconds;
      clock_seconds_ff <= nxt_clock_seconds;
      clock_minutes_ff <= nxt_clock_minutes;
      clock_hours_ff <= nxt_clock_hours;
      weekday_field_ff <= nxt_weekday_field;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      day_count_low_ff <= rtcd_pkg::RST_DAY_BYTE;
      day_count_high_ff <= rtcd_pkg::RST_DAY_BYTE;
    end else begin
      day_count_low_ff <= nxt_day_count_low;
      day_count_high_ff <= nxt_day_count_high;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= rtcd_pkg::RST_READ_DATA;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign sfr_rdata = rdata_ff;

endmodule

`default_nettype wire

// ### sim/rtcd_time_counters_asserts.sv
// Port checker for the time-of-day and day-count block
`timescale 1ns/1ps
`default_nettype none

module rtcd_time_counters_chk #(
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clock_read_enable,
  input wire logic clock_write_enable,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_rd,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_sel,
  input wire logic [7:0] sfr_rdata
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic rd_on;
  assign rd_on = sfr_rd && clock_read_enable;

  chk_rd_gated: assert property (sfr_rd && !clock_read_enable |=> sfr_rdata == 8'h00)
    else $error("read data seen with read enable low");
  chk_sec_top_zero: assert property (rd_on && sfr_addr == 8'hfb |=> sfr_rdata[7:6] == 2'b00)
    else $error("seconds top bits not zero");
  chk_min_top_zero: assert property (rd_on && sfr_addr == 8'hfc |=> sfr_rdata[7:6] == 2'b00)
    else $error("minutes top bits not zero");
  chk_sec_range: assert property (rd_on && sfr_addr == 8'hfb |=> sfr_rdata[5:0] <= 6'h3b)
    else $error("seconds beyond 59");
  chk_hour_range: assert property (rd_on && sfr_addr == 8'hfd |=> sfr_rdata[4:0] <= 5'h17)
    else $error("hours beyond 23");
  chk_unmapped_zero: assert property (sfr_rd && !sfr_sel |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  // Write, one idle cycle, then read back: the day byte cannot tick in between
  chk_day_echo: assert property (sfr_wr && clock_write_enable && sfr_addr == 8'hff ##2
    rd_on && sfr_addr == 8'hff |=> sfr_rdata == $past(sfr_wdata, 3))
    else $error("day high byte lost its write");
endmodule

bind rtcd_time_counters rtcd_time_counters_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .clock_read_enable(clock_read_enable),
  .clock_write_enable(clock_write_enable), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd),
  .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_sel(sfr_sel), .sfr_rdata(sfr_rdata));

`default_nettype wire

// ### sim/rtcd_time_counters_tb_top.sv
// Self-checking bench for the time-of-day and day-count block
`timescale 1ns/1ps
`default_nettype none

module rtcd_time_counters_tb_top;
  // Short tick so a second lasts 1024 cycles
  localparam int unsigned TICKS = 4;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic clock_read_enable = 1'b1;
  logic clock_write_enable = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_rd = 1'b0;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_sel;
  logic [7:0] sfr_rdata;
  logic [7:0] rv;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;

  always #4 ref_clk = ~ref_clk;

  rtcd_time_counters #(.TICK_CYCLES(TICKS)) rtcd_time_counters_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .clock_read_enable(clock_read_enable),
    .clock_write_enable(clock_write_enable), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_sel(sfr_sel), .sfr_rdata(sfr_rdata));

  // ****************
  // Bus helpers
  // ****************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: read %h, wanted %h", $time, seen, exp);
    end
  endtask

  // Strobe drops a cycle early so no task restarts it in the same step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge ref_clk);
    #1 sfr_wr = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge ref_clk);
    #1 sfr_rd = 1'b0;
    rv = sfr_rdata;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_reset;
    for (int i = 0; i < 5; i++) begin
      rd(8'(8'hfb + i));
      check(rv, 8'h00);
      check({7'h00, sfr_sel}, 8'h01);
    end
  endtask

  task automatic t_access;
    clock_write_enable = 1'b1;
    wr(8'hfb, 8'h3b);
    wr(8'hfc, 8'h2a);
    wr(8'hfd, 8'h71);
    wr(8'hff, 8'h5a);
    rd(8'hff);
    check(rv, 8'h5a);
    rd(8'hfb);
    check(rv, 8'h3b);
    rd(8'hfc);
    check(rv, 8'h2a);
    rd(8'hfd);
    check(rv, 8'h71);
    wr(8'hfe, 8'hc3);
    rd(8'hfe);
    check(rv, 8'hc3);
    repeat (120) @(posedge ref_clk);
    #1;
    wr(8'hfa, 8'hc0);
    rd(8'hfa);
    check(rv & 8'hc0, 8'h00);
    clock_write_enable = 1'b0;
    wr(8'hfc, 8'h05);
    rd(8'hfc);
    check(rv, 8'h2a);
    rd(8'hfa);
    check(rv & 8'hf0, 8'h00);
    check({7'h00, sfr_sel}, 8'h01);
    clock_read_enable = 1'b0;
    rd(8'hfc);
    check(rv, 8'h00);
    clock_read_enable = 1'b1;
    rd(8'h80);
    check(rv, 8'h00);
    check({7'h00, sfr_sel}, 8'h00);
  endtask

  // Dropping write enable zeroes the subseconds, so the wrap lands near 1024 cycles
  task automatic t_cascade(input logic [7:0] hr, lo, hi, e_hr, e_lo, e_hi);
    clock_write_enable = 1'b1;
    wr(8'hfb, 8'h3b);
    wr(8'hfc, 8'h3b);
    wr(8'hfd, hr);
    wr(8'hfe, lo);
    wr(8'hff, hi);
    clock_write_enable = 1'b0;
    repeat (990) @(posedge ref_clk);
    #1;
    rd(8'hfb);
    check(rv, 8'h3b);
    repeat (40) @(posedge ref_clk);
    #1;
    rd(8'hfb);
    check(rv, 8'h00);
    rd(8'hfc);
    check(rv, 8'h00);
    rd(8'hfd);
    check(rv, e_hr);
    rd(8'hfe);
    check(rv, e_lo);
    rd(8'hff);
    check(rv, e_hi);
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    t_reset();
    t_access();
    t_cascade(8'h17, 8'hff, 8'h12, 8'h00, 8'h00, 8'h13);
    t_cascade(8'hf7, 8'hff, 8'hff, 8'h20, 8'h00, 8'h00);
    report_and_stop();
  end
endmodule

`default_nettype wire
